// *** uls_defs.svh ***
// register offsets, field positions and reset values of the line/modem status block
`ifndef ULS_DEFS_SVH
`define ULS_DEFS_SVH

// ---------------------------------------------------------------
// byte offsets on the register bus
// ---------------------------------------------------------------
`define ULS_OFS_FIFO_CTRL   5'h08
`define ULS_OFS_MODEM_CTRL  5'h10
`define ULS_OFS_LINE_STAT   5'h14
`define ULS_OFS_MODEM_STAT  5'h18

// ---------------------------------------------------------------
// fifo_control_reg fields
// ---------------------------------------------------------------
`define ULS_FC_ENABLE       0
`define ULS_FC_RX_RESET     1

// ---------------------------------------------------------------
// modem_control fields
// ---------------------------------------------------------------
`define ULS_MC_DTR          0
`define ULS_MC_RTS          1
`define ULS_MC_RING         2
`define ULS_MC_IRQ_EN       3
`define ULS_MC_LOOP         4
`define ULS_MC_W            5

// ---------------------------------------------------------------
// per-character error tag fields
// ---------------------------------------------------------------
`define ULS_TAG_PARITY      0
`define ULS_TAG_FRAMING     1
`define ULS_TAG_SILENT      2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ULS_MC_RESET        5'h00
`define ULS_LS_RESET        8'h60

`endif

// *** uls_pkg.sv ***
// types shared by the line/modem status block
package uls_pkg;

    // receive buffering mode
    typedef enum logic {ULS_UNBUF, ULS_BUF} uls_mode_t;

    // error tag carried with each received character
    typedef logic [2:0] uls_tag_t;

endpackage : uls_pkg

// *** uls_modem_in.sv ***
// modem input sampler with sticky change flags
`timescale 1ns/1ns
module uls_modem_in #(
    parameter int         N         = 4,
    parameter logic [3:0] TRAIL_MSK = 4'b0100
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // active-low inputs, already muxed for loopback
    input  wire logic [N-1:0] pin_n_i,
    // read of the status register
    input  wire logic         clr_i,
    // current state and change flags
    output logic      [N-1:0] state_o,
    output logic      [N-1:0] chg_o
);

    logic [N-1:0] pin_q_reg;
    logic [N-1:0] chg_reg;
    logic         vld_reg;
    logic [N-1:0] evt;

    // ---------------------------------------------------------------
    // edge detection per input
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_in
            if (TRAIL_MSK[g])
            begin : g_trail
                // only low-to-high of the pin counts here
                assign evt[g] = vld_reg & pin_n_i[g] & ~pin_q_reg[g];
            end
            else
            begin : g_tog
                assign evt[g] = vld_reg & (pin_n_i[g] ^ pin_q_reg[g]);
            end
        end
    endgenerate

    // first sample after reset has no history, so it never flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_q_reg <= '1;
            chg_reg   <= '0;
            vld_reg   <= 1'b0;
        end
        else
        begin
            pin_q_reg <= pin_n_i;
            vld_reg   <= 1'b1;
            chg_reg   <= evt | (chg_reg & ~{N{clr_i}});
        end
    end

    // status reads as the complement of the active-low pins
    assign state_o = ~pin_q_reg;
    assign chg_o   = chg_reg;

endmodule : uls_modem_in

// *** uls_top.sv ***
// line status, modem control and modem status of a serial port
// ---------------------------------------------------------------
// Overview of operation
// - fifo error flag only in buffered mode
// - status read clears it once errors gone
// - idle flag needs shift and holding empty
// - holding-empty sets on move, clears on write
// - holding-empty with enable raises interrupt; code raises it only when the flag sets while enabled
// - silent line for char time sets flag
// - missing stop bit sets framing flag
// - wrong parity sets parity flag
// - unread character overwritten sets overrun flag
// - data ready while any character waits
// - buffered error flags follow fifo head
// - loopback: output high, input ignored, outputs off
// - loopback feeds modem inputs from control bits
// - interrupt driven only while enabled
// - rts and dtr pins are inverted bits
// - status bits complement pins or loop bits
// - toggle flags for carrier, ready, clear
// - ring trailing edge flag on rise
// - fifo enable bit selects buffered mode
// ---------------------------------------------------------------
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "uls_defs.svh"
module uls_top
    import uls_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // receiver side
    input  wire logic        rx_push_i,
    input  wire logic        rx_par_err_i,
    input  wire logic        rx_frm_err_i,
    input  wire logic        rx_pop_i,
    input  wire logic [15:0] char_clks_i,
    // transmitter side
    input  wire logic        tx_write_i,
    input  wire logic        tx_load_i,
    input  wire logic        tx_fifo_empty_i,
    input  wire logic        tx_shift_empty_i,
    input  wire logic        tx_serial_i,
    // interrupt side
    input  wire logic        holding_empty_irq_enable_i,
    input  wire logic        uart_irq_i,
    // pins
    input  wire logic        serial_in_i,
    input  wire logic        cts_n_i,
    input  wire logic        dsr_n_i,
    input  wire logic        ri_n_i,
    input  wire logic        dcd_n_i,
    output logic             serial_out_o,
    output logic             rts_n_o,
    output logic             dtr_n_o,
    output logic             irq_o,
    output logic             irq_oe_o,
    // to receiver and interrupt logic
    output logic             rx_serial_o,
    output logic             data_ready_o,
    output logic             holding_empty_o
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    wire bus_rd  = bus_req & ~wb_we_i;
    wire hit_fc  = wb_adr_i == `ULS_OFS_FIFO_CTRL;
    wire hit_mc  = wb_adr_i == `ULS_OFS_MODEM_CTRL;
    wire hit_ls  = wb_adr_i == `ULS_OFS_LINE_STAT;
    wire hit_ms  = wb_adr_i == `ULS_OFS_MODEM_STAT;
    wire ls_rd   = bus_rd & hit_ls;
    wire ms_rd   = bus_rd & hit_ms;

    logic [`ULS_MC_W-1:0] mc_reg;
    logic                 fc_en_reg;

    // mode switch flushes the shadow queue, like an rx reset
    wire fc_wr    = bus_wr & hit_fc;
    wire rx_flush = fc_wr & (wb_dat_i[`ULS_FC_RX_RESET]
                    | (wb_dat_i[`ULS_FC_ENABLE] != fc_en_reg));
    uls_mode_t mode;
    assign mode = fc_en_reg ? ULS_BUF : ULS_UNBUF;
    wire buf_m  = mode == ULS_BUF;
    wire loop_m = mc_reg[`ULS_MC_LOOP];

    // control registers; only byte lane 0 carries data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mc_reg    <= `ULS_MC_RESET;
            fc_en_reg <= 1'b0;
        end
        else
        begin
            if (bus_wr & hit_mc)
                mc_reg <= wb_dat_i[`ULS_MC_W-1:0];
            if (fc_wr)
                fc_en_reg <= wb_dat_i[`ULS_FC_ENABLE];
        end
    end

    // ---------------------------------------------------------------
    // silent line detector
    // ---------------------------------------------------------------
    logic [15:0] sil_cnt_reg;
    logic        brk_pend_reg;

    // loopback isolates the pin and feeds the receiver internally
    wire line_w  = loop_m ? tx_serial_i : serial_in_i;
    wire sil_inc = ~rx_serial_o & (sil_cnt_reg != char_clks_i);
    wire brk_evt = ~rx_serial_o & ((sil_cnt_reg + 16'h0001) == char_clks_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_serial_o <= 1'b1;
            sil_cnt_reg <= 16'h0000;
        end
        else
        begin
            rx_serial_o <= line_w;
            if (rx_serial_o)
                sil_cnt_reg <= 16'h0000;
            else if (sil_inc)
                sil_cnt_reg <= sil_cnt_reg + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // shadow of the receive queue: one error tag per character
    // ---------------------------------------------------------------
    uls_tag_t       tag_mem [DEPTH];
    logic [PW-1:0]  wp_reg;
    logic [PW-1:0]  rp_reg;
    logic [CW-1:0]  cnt_reg;
    logic [CW-1:0]  ecnt_reg;

    // unbuffered mode is a queue of one that overwrites
    wire [CW-1:0] cap_w   = buf_m ? CW'(DEPTH) : CW'(1);
    wire          full_w  = cnt_reg == cap_w;
    wire          pop_w   = rx_pop_i & (cnt_reg != '0);
    wire          st_w    = rx_push_i & (~full_w | pop_w);
    wire          ovr_w   = rx_push_i & full_w & ~pop_w;
    wire          ow_w    = ovr_w & ~buf_m;
    uls_tag_t     ptag;
    assign ptag = {brk_pend_reg | brk_evt, rx_frm_err_i, rx_par_err_i};
    wire          perr_w  = |ptag;
    uls_tag_t     head_t;
    assign head_t = tag_mem[rp_reg];
    wire          herr_w  = |head_t;
    wire [PW-1:0] rp_nx   = rp_reg + PW'(1);
    wire          e_inc   = (st_w | ow_w) & perr_w;
    wire          e_dec   = (pop_w | ow_w) & herr_w;
    wire [CW-1:0] cnt_next  = cnt_reg + CW'(st_w) - CW'(pop_w);
    wire [CW-1:0] ecnt_next = ecnt_reg + CW'(e_inc) - CW'(e_dec);

    // tag storage has no reset; pointers gate every read
    always_ff @(posedge clk_i)
    begin
        if (st_w)
            tag_mem[wp_reg] <= ptag;
        else if (ow_w)
            tag_mem[rp_reg] <= ptag;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i | rx_flush)
        begin
            wp_reg   <= '0;
            rp_reg   <= '0;
            cnt_reg  <= '0;
            ecnt_reg <= '0;
        end
        else
        begin
            if (st_w)
                wp_reg <= wp_reg + PW'(1);
            if (pop_w)
                rp_reg <= rp_nx;
            cnt_reg  <= cnt_next;
            ecnt_reg <= ecnt_next;
        end
    end

    // a pending silent line rides on the next stored character
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            brk_pend_reg <= 1'b0;
        else
            brk_pend_reg <= (brk_evt & buf_m) | (brk_pend_reg & ~(st_w | ow_w));
    end

    // ---------------------------------------------------------------
    // line status flags
    // ---------------------------------------------------------------
    // the flags follow whichever character becomes the head
    wire load_new = (st_w & ((cnt_reg == '0) | (pop_w & (cnt_reg == CW'(1))))) | ow_w;
    wire load_nxt = pop_w & (cnt_reg > CW'(1));
    uls_tag_t hd_set;
    assign hd_set = load_new ? ptag
                  : load_nxt ? tag_mem[rp_nx]
                  : 3'b000;
    uls_tag_t brk_set;
    assign brk_set = {brk_evt & ~buf_m, 2'b00};

    uls_tag_t fl_reg;
    logic     ovr_reg;
    logic     ferr_reg;
    logic     he_reg;
    logic     txe_d_reg;
    logic     thp_reg;

    // set wins over a clearing read in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i | rx_flush)
        begin
            fl_reg   <= 3'b000;
            ovr_reg  <= 1'b0;
            ferr_reg <= 1'b0;
        end
        else
        begin
            fl_reg   <= hd_set | brk_set | (fl_reg & ~{3{ls_rd}});
            ovr_reg  <= ovr_w | (ovr_reg & ~ls_rd);
            ferr_reg <= buf_m & ((ecnt_next != '0) | (ferr_reg & ~ls_rd));
        end
    end

    // ---------------------------------------------------------------
    // transmit status and holding-empty interrupt
    // ---------------------------------------------------------------
    wire he_set = buf_m ? (tx_fifo_empty_i & ~txe_d_reg) : tx_load_i;
    wire idle_w = tx_shift_empty_i & (buf_m ? tx_fifo_empty_i : he_reg);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            he_reg    <= 1'b1;
            txe_d_reg <= 1'b1;
            thp_reg   <= 1'b0;
        end
        else
        begin
            txe_d_reg <= tx_fifo_empty_i;
            he_reg    <= he_set | (he_reg & ~tx_write_i);
            thp_reg   <= holding_empty_irq_enable_i
                         & ((he_set) | (thp_reg & ~tx_write_i));
        end
    end

    // ---------------------------------------------------------------
    // modem inputs, loopback steering
    // ---------------------------------------------------------------
    logic [3:0] pin_n;
    logic [3:0] ms_state;
    logic [3:0] ms_chg;

    // order: carrier, ring, set ready, clear to send
    assign pin_n = loop_m ? ~{mc_reg[`ULS_MC_IRQ_EN], mc_reg[`ULS_MC_RING],
                              mc_reg[`ULS_MC_DTR], mc_reg[`ULS_MC_RTS]}
                          : {dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};

    uls_modem_in #(
        .N         (4),
        .TRAIL_MSK (4'b0100)
    ) u_modem_in (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_n_i (pin_n),
        .clr_i   (ms_rd),
        .state_o (ms_state),
        .chg_o   (ms_chg)
    );

    // ---------------------------------------------------------------
    // pins and interrupt output
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            serial_out_o    <= 1'b1;
            rts_n_o         <= 1'b1;
            dtr_n_o         <= 1'b1;
            irq_o           <= 1'b0;
            irq_oe_o        <= 1'b0;
            data_ready_o    <= 1'b0;
            holding_empty_o <= 1'b1;
        end
        else
        begin
            serial_out_o    <= loop_m | tx_serial_i;
            rts_n_o         <= loop_m | ~mc_reg[`ULS_MC_RTS];
            dtr_n_o         <= loop_m | ~mc_reg[`ULS_MC_DTR];
            irq_o           <= mc_reg[`ULS_MC_IRQ_EN] & (uart_irq_i | thp_reg);
            irq_oe_o        <= mc_reg[`ULS_MC_IRQ_EN];
            // a flush empties the queue, so data ready must drop with it
            data_ready_o    <= ~rx_flush & (cnt_next != '0);
            holding_empty_o <= he_set | (he_reg & ~tx_write_i);
        end
    end

    // ---------------------------------------------------------------
    // read mux and acknowledge
    // ---------------------------------------------------------------
    wire [7:0] ls_val = {ferr_reg, idle_w, he_reg, fl_reg, ovr_reg,
                         cnt_reg != '0};
    wire [7:0] ms_val = {ms_state, ms_chg};
    wire [7:0] rd_val = hit_ls ? ls_val
                      : hit_ms ? ms_val
                      : hit_mc ? {3'b000, mc_reg}
                      : hit_fc ? {7'h00, fc_en_reg}
                      : 8'h00;

    // one wait state; unmapped reads answer zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_rd)
                wb_dat_o <= {24'h00_0000, rd_val};
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_FERR_UNBUF: assert property (@(posedge clk_i) disable iff (rst_i)
        !fc_en_reg && !$past(fc_en_reg) |-> !ferr_reg)
        else $error("fifo error flag set in unbuffered mode");

    AST_HE_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_write_i && !he_set |=> !he_reg && !holding_empty_o)
        else $error("holding empty not cleared by write");

    AST_OVR: assert property (@(posedge clk_i) disable iff (rst_i)
        ovr_w && !rx_flush |=> ovr_reg ##1 (ovr_reg || $past(ls_rd)))
        else $error("overrun not flagged");

    AST_DR: assert property (@(posedge clk_i) disable iff (rst_i)
        data_ready_o == (cnt_reg != '0))
        else $error("data ready disagrees with queue");

    AST_PAR_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        ls_rd && !hd_set[0] |=> !fl_reg[0])
        else $error("parity flag survived status read");

    AST_LOOP_PINS: assert property (@(posedge clk_i) disable iff (rst_i)
        loop_m |=> serial_out_o && rts_n_o && dtr_n_o)
        else $error("loopback left a pin active");

    AST_RTS: assert property (@(posedge clk_i) disable iff (rst_i)
        !loop_m |=> rts_n_o == !$past(mc_reg[`ULS_MC_RTS]))
        else $error("request pin not inverse of bit");

    AST_IRQ_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !mc_reg[`ULS_MC_IRQ_EN] |=> !irq_o && !irq_oe_o)
        else $error("interrupt driven while disabled");

    AST_LOOP_DSR: assert property (@(posedge clk_i) disable iff (rst_i)
        loop_m && $stable(mc_reg) |=> ms_state[1] == $past(mc_reg[`ULS_MC_DTR]))
        else $error("loopback ready input not fed");

    AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");

endmodule : uls_top

// *** uls_modem_model.sv ***
// modem-side model driving the handshake pins and the serial line
`timescale 1ns/1ns
module uls_modem_model (
    // clock and requested line states
    input  wire logic       clk_i,
    input  wire logic [3:0] lvl_i,
    input  wire logic       brk_i,
    // active-low handshake pins and serial line
    output logic            cts_n_o,
    output logic            dsr_n_o,
    output logic            ri_n_o,
    output logic            dcd_n_o,
    output logic            serial_in_o
);
    initial {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o, serial_in_o} = 5'h1f;
    // pins move just after an edge, like a synchronous peer would
    always @(posedge clk_i)
    begin
        {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} <= ~lvl_i;
        serial_in_o <= ~brk_i; // rests at mark, a break holds it low
    end
endmodule : uls_modem_model

// *** tb.sv ***
// self-checking bench of the line/modem status block
`timescale 1ns/1ns
`include "uls_defs.svh"
module tb;
    localparam int LIMIT = 5000;
    // bus, event and pin stimulus
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0]  wb_adr_i = 5'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic        rx_push_i = 1'b0, rx_par_err_i = 1'b0, rx_frm_err_i = 1'b0, rx_pop_i = 1'b0;
    logic [15:0] char_clks_i = 16'h0000;
    logic        tx_write_i = 1'b0, tx_load_i = 1'b0, tx_serial_i = 1'b1;
    logic        tx_fifo_empty_i = 1'b1, tx_shift_empty_i = 1'b1;
    logic        holding_empty_irq_enable_i = 1'b0, uart_irq_i = 1'b0;
    logic [3:0]  lvl = 4'h0;
    logic        brk = 1'b0;
    // design outputs and pins
    logic        serial_in_i, cts_n_i, dsr_n_i, ri_n_i, dcd_n_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, serial_out_o, rts_n_o, dtr_n_o, irq_o, irq_oe_o;
    logic        rx_serial_o, data_ready_o, holding_empty_o;
    // reference model state
    int          pe, fe, sb, oe, he, ferr, fifo_on, mismatches, n_tests, cycles;
    int          tagq[$];

    uls_top #(.DEPTH(16)) uls_top_i (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .rx_push_i, .rx_par_err_i, .rx_frm_err_i, .rx_pop_i,
        .char_clks_i, .tx_write_i, .tx_load_i, .tx_fifo_empty_i, .tx_shift_empty_i,
        .tx_serial_i, .holding_empty_irq_enable_i, .uart_irq_i, .serial_in_i, .cts_n_i,
        .dsr_n_i, .ri_n_i, .dcd_n_i, .serial_out_o, .rts_n_o, .dtr_n_o, .irq_o, .irq_oe_o,
        .rx_serial_o, .data_ready_o, .holding_empty_o
    );
    uls_modem_model uls_modem_model_i (
        .clk_i, .lvl_i(lvl), .brk_i(brk), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i),
        .ri_n_o(ri_n_i), .dcd_n_o(dcd_n_i), .serial_in_o(serial_in_i)
    );

    // ---------------------------------------------------------------
    // clock, timeout and shared tasks
    // ---------------------------------------------------------------
    always #5 clk_i = ~clk_i;

    // a hang ends the run as a mismatch
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // classic single cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        tick(1);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do tick(1); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic chk_rd(input string name, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(name, q, e);
    endtask : chk_rd

    function automatic logic [7:0] exp_ls();
        logic idle;
        idle = tx_shift_empty_i & (fifo_on ? tx_fifo_empty_i : he[0]);
        return {ferr[0], idle, he[0], sb[0], fe[0], pe[0], oe[0], tagq.size() != 0};
    endfunction : exp_ls

    // a status read reports, then clears the sticky error flags
    task automatic ls_rd();
        int n;
        chk_rd("line_status", `ULS_OFS_LINE_STAT, exp_ls());
        pe = 0;
        fe = 0;
        sb = 0;
        oe = 0;
        n = 0;
        foreach (tagq[i]) n += (tagq[i] != 0);
        if (n == 0) ferr = 0;
    endtask : ls_rd

    // one received character; unbuffered mode keeps only the newest
    task automatic push(input int p, input int f);
        tick(1);
        rx_push_i    <= 1'b1;
        rx_par_err_i <= p[0];
        rx_frm_err_i <= f[0];
        tick(1);
        rx_push_i <= 1'b0;
        if (!fifo_on && tagq.size() != 0)
        begin
            oe = 1;
            tagq.delete();
        end
        if (tagq.size() == 0)
        begin
            pe |= p;
            fe |= f;
        end
        tagq.push_back(p | (f << 1));
        if (fifo_on && (p | f)) ferr = 1;
    endtask : push

    task automatic pop();
        tick(1);
        rx_pop_i <= 1'b1;
        tick(1);
        rx_pop_i <= 1'b0;
        void'(tagq.pop_front());
        if (fifo_on && tagq.size() != 0)
        begin
            pe |= tagq[0] & 1;
            fe |= tagq[0] >> 1;
        end
    endtask : pop

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        logic [7:0] r;
        logic [7:0] q;
        void'($urandom(32'h555f_8625));
        he = 1;
        tick(5);
        rst_i <= 1'b0;
        ls_rd();
        chk_rd("modem_control", `ULS_OFS_MODEM_CTRL, 8'h00);
        wr(5'h04, 8'hff);
        chk_rd("unmapped", 5'h04, 8'h00);
        // pin states, change flags and their clearing
        chk_rd("modem_status", `ULS_OFS_MODEM_STAT, 8'h00);
        lvl <= 4'hf;
        tick(4);
        chk_rd("modem_status", `ULS_OFS_MODEM_STAT, 8'hfb);
        chk_rd("modem_status", `ULS_OFS_MODEM_STAT, 8'hf0);
        lvl <= 4'h0;
        tick(4);
        chk_rd("modem_status", `ULS_OFS_MODEM_STAT, 8'h0f);
        chk_rd("modem_status", `ULS_OFS_MODEM_STAT, 8'h00);
        repeat (3)
        begin
            r = 8'($urandom) & 8'h03;
            wr(`ULS_OFS_MODEM_CTRL, r);
            tick(3);
            check("rts_n", rts_n_o, !r[1]);
            check("dtr_n", dtr_n_o, !r[0]);
            chk_rd("modem_control", `ULS_OFS_MODEM_CTRL, r);
        end
        // holding-empty flag and interrupt gating
        holding_empty_irq_enable_i <= 1'b1;
        wr(`ULS_OFS_MODEM_CTRL, 8'h08);
        tx_write_i <= 1'b1;
        tick(1);
        tx_write_i <= 1'b0;
        he = 0;
        tick(4);
        check("holding_empty", holding_empty_o, 1'b0);
        check("irq", irq_o, 1'b0);
        ls_rd();
        tx_load_i <= 1'b1;
        tick(1);
        tx_load_i <= 1'b0;
        he = 1;
        tick(4);
        check("holding_empty", holding_empty_o, 1'b1);
        check("irq", irq_o, 1'b1);
        check("irq_oe", irq_oe_o, 1'b1);
        wr(`ULS_OFS_MODEM_CTRL, 8'h00);
        tick(4);
        check("irq", irq_o, 1'b0);
        check("irq_oe", irq_oe_o, 1'b0);
        // unbuffered receive errors, overrun and a silent line
        push(1, 0);
        tick(2);
        check("data_ready", data_ready_o, 1'b1);
        ls_rd();
        push(0, 1);
        ls_rd();
        pop();
        ls_rd();
        char_clks_i <= 16'h0008;
        brk <= 1'b1;
        tick(20);
        brk <= 1'b0;
        tick(4);
        sb = 1;
        ls_rd();
        ls_rd();
        char_clks_i <= 16'h0000;
        // buffered mode: flags follow the head character
        wr(`ULS_OFS_FIFO_CTRL, 8'h01);
        fifo_on = 1;
        chk_rd("fifo_control", `ULS_OFS_FIFO_CTRL, 8'h01);
        push(0, 0);
        push(1, 0);
        ls_rd();
        pop();
        ls_rd();
        pop();
        ls_rd();
        ls_rd();
        // buffered transmit: busy shifter and fifo hold idle low
        tx_fifo_empty_i  <= 1'b0;
        tx_shift_empty_i <= 1'b0;
        tx_write_i       <= 1'b1;
        tick(1);
        tx_write_i <= 1'b0;
        he = 0;
        ls_rd();
        tx_fifo_empty_i <= 1'b1;
        tick(2);
        he = 1;
        ls_rd();
        tx_shift_empty_i <= 1'b1;
        // receive reset drops queued characters and their flags
        push(1, 1);
        wr(`ULS_OFS_FIFO_CTRL, 8'h03);
        tagq.delete();
        pe = 0;
        fe = 0;
        ferr = 0;
        tick(1);
        check("data_ready", data_ready_o, 1'b0);
        ls_rd();
        wr(`ULS_OFS_FIFO_CTRL, 8'h00);
        fifo_on = 0;
        // loopback: pins parked, inputs fed from control bits
        tx_serial_i <= 1'b0;
        tick(3);
        check("serial_out", serial_out_o, 1'b0);
        repeat (4)
        begin
            r = 8'($urandom) & 8'h0f;
            wr(`ULS_OFS_MODEM_CTRL, 8'h10 | r);
            tick(3);
            bus(1'b0, `ULS_OFS_MODEM_STAT, 8'h00, q);
            check("loop_status", q[7:4], {r[3], r[2], r[0], r[1]});
            check("rts_n", rts_n_o, 1'b1);
            check("dtr_n", dtr_n_o, 1'b1);
            check("serial_out", serial_out_o, 1'b1);
            check("rx_serial", rx_serial_o, 1'b0);
        end
        wr(`ULS_OFS_MODEM_CTRL, 8'h00);
        tx_serial_i <= 1'b1;
        conclude();
    end
endmodule : tb
